// ==== src/channel_sync_holdoff_control.sv ====
`timescale 1ns/1ps
module channel_sync_holdoff_control
  import sync_holdoff_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire reg_req_t                req,
  output logic [DATA_W-1:0]            reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic                    sync_pin,
  output mem_wr_t                      mem_wr,
  output chan_out_t [NUM_CH-1:0]       chan_out
);

  logic [7:0]        mode_q, mode_d;
  logic [7:0]        sync_q, sync_d;
  logic [7:0]        ctrl_q [NUM_CH];
  logic [7:0]        ctrl_d [NUM_CH];
  logic [CNT_W-1:0]  start_load_q [NUM_CH];
  logic [CNT_W-1:0]  start_load_d [NUM_CH];
  logic [CNT_W-1:0]  freq_load_q [NUM_CH];
  logic [CNT_W-1:0]  freq_load_d [NUM_CH];
  logic [FREQ_W-1:0] freq_shadow_q [NUM_CH];
  logic [FREQ_W-1:0] freq_shadow_d [NUM_CH];
  logic [FREQ_W-1:0] freq_live_q [NUM_CH];
  logic [FREQ_W-1:0] freq_live_d [NUM_CH];
  logic [FREQ_W-1:0] phase_q [NUM_CH];
  logic [FREQ_W-1:0] phase_d [NUM_CH];
  logic [CNT_W-1:0]  start_cnt_q [NUM_CH];
  logic [CNT_W-1:0]  start_cnt_d [NUM_CH];
  logic [CNT_W-1:0]  freq_cnt_q [NUM_CH];
  logic [CNT_W-1:0]  freq_cnt_d [NUM_CH];
  hold_state_t       start_st_q [NUM_CH];
  hold_state_t       start_st_d [NUM_CH];
  hold_state_t       freq_st_q [NUM_CH];
  hold_state_t       freq_st_d [NUM_CH];
  logic [NUM_CH-1:0] active_q, active_d;
  logic [NUM_CH-1:0] start_trig, hop_trig, sync_evt, start_done, freq_done, ch_wr;
  logic              sync_meta_q, sync_lvl_q, sync_old_q, pin_rise, soft_wr;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q;
  mem_wr_t           mem_q, mem_d;
  logic              mem_ok;

  // Sync pin passes two flops, then a third flop gives the rising edge.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_meta_q <= 1'b0;
      sync_lvl_q  <= 1'b0;
      sync_old_q  <= 1'b0;
    end else begin
      sync_meta_q <= sync_pin;
      sync_lvl_q  <= sync_meta_q;
      sync_old_q  <= sync_lvl_q;
    end
  end

  // Trigger decode: a soft sync is a write to the sync register, a pin sync is a sampled rising edge.
  always_comb begin
    pin_rise = sync_lvl_q & ~sync_old_q;
    soft_wr  = req.wr & req.ext & (req.addr == EXT_SYNC);
    for (int c = 0; c < NUM_CH; c++) begin
      ch_wr[c]      = req.wr & ~req.ext & (req.ch == 2'(c));
      sync_evt[c]   = (soft_wr & req.data[SYNC_SEL_LSB + c]) | (pin_rise & ctrl_q[c][CTRL_PIN_EN]);
      start_trig[c] = (soft_wr & req.data[SYNC_START] & req.data[SYNC_SEL_LSB + c]) |
                      (pin_rise & ctrl_q[c][CTRL_PIN_EN] & ctrl_q[c][CTRL_START_PIN]);
      hop_trig[c]   = (soft_wr & req.data[SYNC_HOP] & req.data[SYNC_SEL_LSB + c]) |
                      (pin_rise & ctrl_q[c][CTRL_PIN_EN] & ctrl_q[c][CTRL_HOP_PIN]);
    end
  end

  // Hold-off counters: load on trigger, count down, finish at a count of one or zero.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      start_cnt_d[c] = start_cnt_q[c];
      start_st_d[c]  = start_st_q[c];
      start_done[c]  = 1'b0;
      freq_cnt_d[c]  = freq_cnt_q[c];
      freq_st_d[c]   = freq_st_q[c];
      freq_done[c]   = 1'b0;
      unique case (start_st_q[c])
        HOLD_IDLE: begin
          if (start_trig[c]) begin
            start_cnt_d[c] = start_load_q[c];
            start_st_d[c]  = HOLD_COUNT;
          end
        end
        HOLD_COUNT: begin
          if (start_cnt_q[c] <= CNT_ONE) begin
            start_done[c] = 1'b1;
            start_st_d[c] = HOLD_IDLE;
          end else begin
            start_cnt_d[c] = start_cnt_q[c] - CNT_ONE;
          end
        end
      endcase
      unique case (freq_st_q[c])
        HOLD_IDLE: begin
          if (hop_trig[c]) begin
            freq_cnt_d[c] = freq_load_q[c];
            freq_st_d[c]  = HOLD_COUNT;
          end
        end
        HOLD_COUNT: begin
          if (freq_cnt_q[c] <= CNT_ONE) begin
            freq_done[c] = 1'b1;
            freq_st_d[c] = HOLD_IDLE;
          end else begin
            freq_cnt_d[c] = freq_cnt_q[c] - CNT_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst) begin
        start_cnt_q[c] <= CNT_ZERO;
        start_st_q[c]  <= HOLD_IDLE;
        freq_cnt_q[c]  <= CNT_ZERO;
        freq_st_q[c]   <= HOLD_IDLE;
      end else begin
        start_cnt_q[c] <= start_cnt_d[c];
        start_st_q[c]  <= start_st_d[c];
        freq_cnt_q[c]  <= freq_cnt_d[c];
        freq_st_q[c]   <= freq_st_d[c];
      end
    end
  end

  // Register writes, shadow transfers, sleep release and the phase accumulator.
  always_comb begin
    mode_d = mode_q;
    sync_d = sync_q;
    if (req.wr && req.ext && req.addr == EXT_MODE) begin
      mode_d = req.data[7:0];
    end
    if (soft_wr) begin
      sync_d = req.data[7:0];
    end
    for (int c = 0; c < NUM_CH; c++) begin
      ctrl_d[c]        = ctrl_q[c];
      start_load_d[c]  = start_load_q[c];
      freq_load_d[c]   = freq_load_q[c];
      freq_shadow_d[c] = freq_shadow_q[c];
      freq_live_d[c]   = freq_live_q[c];
      if (ch_wr[c]) begin
        unique case (req.addr)
          CH_START_HOLDOFF: start_load_d[c] = req.data[CNT_W-1:0];
          CH_OSC_CTRL:      ctrl_d[c]       = req.data[7:0];
          CH_FREQ_HOLDOFF:  freq_load_d[c]  = req.data[CNT_W-1:0];
          CH_FREQ: begin
            freq_shadow_d[c] = req.data;
            if (freq_load_q[c] == CNT_ZERO && freq_st_q[c] == HOLD_IDLE) begin
              freq_live_d[c] = req.data;
            end
          end
          default: ;
        endcase
      end
      if (freq_done[c]) begin
        freq_live_d[c] = freq_shadow_q[c];
      end
      if (start_done[c]) begin
        mode_d[MODE_SLEEP_LSB + c] = 1'b0;
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // Run only when both bits low.
      active_d[c] = ~mode_d[MODE_PROG_LSB + c] & ~mode_d[MODE_SLEEP_LSB + c];
      if (sync_evt[c] && ctrl_q[c][CTRL_PHASE_CLR]) begin
        phase_d[c] = WORD_ZERO;
      end else if (active_q[c]) begin
        phase_d[c] = phase_q[c] + freq_live_q[c];
      end else begin
        phase_d[c] = phase_q[c];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q   <= MODE_RST;
      sync_q   <= SYNC_RST;
      active_q <= '0;
    end else begin
      mode_q   <= mode_d;
      sync_q   <= sync_d;
      active_q <= active_d;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst) begin
        ctrl_q[c]        <= CTRL_RST;
        start_load_q[c]  <= CNT_ZERO;
        freq_load_q[c]   <= CNT_ZERO;
        freq_shadow_q[c] <= WORD_ZERO;
        freq_live_q[c]   <= WORD_ZERO;
        phase_q[c]       <= WORD_ZERO;
      end else begin
        ctrl_q[c]        <= ctrl_d[c];
        start_load_q[c]  <= start_load_d[c];
        freq_load_q[c]   <= freq_load_d[c];
        freq_shadow_q[c] <= freq_shadow_d[c];
        freq_live_q[c]   <= freq_live_d[c];
        phase_q[c]       <= phase_d[c];
      end
    end
  end

  // Read mux and the gated memory write port.
  always_comb begin
    rdata_d = '0;
    if (req.ext) begin
      unique case (req.addr)
        EXT_MODE:   rdata_d[7:0] = mode_q;
        EXT_SYNC:   rdata_d[7:0] = sync_q;
        EXT_STATUS: rdata_d[7:0] = {start_st_q[3] == HOLD_COUNT, start_st_q[2] == HOLD_COUNT,
                                     start_st_q[1] == HOLD_COUNT, start_st_q[0] == HOLD_COUNT,
                                     active_q};
        default:    rdata_d = '0;
      endcase
    end else begin
      unique case (req.addr)
        CH_START_HOLDOFF: rdata_d[CNT_W-1:0] = start_load_q[req.ch];
        CH_OSC_CTRL:      rdata_d[7:0]       = ctrl_q[req.ch];
        CH_FREQ:          rdata_d            = freq_shadow_q[req.ch];
        CH_FREQ_HOLDOFF:  rdata_d[CNT_W-1:0] = freq_load_q[req.ch];
        default:          rdata_d            = '0;
      endcase
    end
    mem_ok     = mode_q[MODE_PROG_LSB + int'(req.ch)];
    mem_d      = '0;
    mem_d.we   = req.wr & ~req.ext & req.addr[CH_MEM_BIT] & mem_ok;
    mem_d.ch   = req.ch;
    mem_d.addr = req.addr[6:0];
    mem_d.data = req.data;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      mem_q    <= '0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= req.rd;
      mem_q    <= mem_d;
    end
  end

  // Outputs are driven straight from registers.
  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign mem_wr     = mem_q;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      chan_out[c].active  = active_q[c];
      chan_out[c].scale   = ctrl_q[c][CTRL_SCALE_LSB +: 2];
      chan_out[c].pdither = ctrl_q[c][CTRL_PDITHER];
      chan_out[c].adither = ctrl_q[c][CTRL_ADITHER];
      chan_out[c].freq    = freq_live_q[c];
      chan_out[c].phase   = phase_q[c];
    end
  end

  // Checks on the counters, shadow, phase, memory gate and mode bits.
  a_reset_sleep: assert property (@(posedge ref_clk) $past(rst) |-> mode_q[7:4] == 4'hF)
    else $error("channels not asleep after reset");
  a_mem_gate: assert property (@(posedge ref_clk) disable iff (rst) mem_q.we |-> $past(mem_ok))
    else $error("memory write accepted outside program mode");
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    a_start_load: assert property (@(posedge ref_clk) disable iff (rst)
      (start_st_q[g] == HOLD_IDLE && start_trig[g]) |=> (start_cnt_q[g] == $past(start_load_q[g])))
      else $error("start counter not loaded on trigger");
    a_start_step: assert property (@(posedge ref_clk) disable iff (rst)
      (start_st_q[g] == HOLD_COUNT && start_cnt_q[g] > CNT_ONE) |=> (start_cnt_q[g] == $past(start_cnt_q[g]) - CNT_ONE))
      else $error("start counter did not step down by one");
    a_start_wake: assert property (@(posedge ref_clk) disable iff (rst)
      start_done[g] |=> !mode_q[MODE_SLEEP_LSB + g])
      else $error("sleep bit not cleared at completion");
    a_single_update: assert property (@(posedge ref_clk) disable iff (rst)
      start_done[g] |=> (start_st_q[g] == HOLD_IDLE) && !start_done[g])
      else $error("start counter kept running after completion");
    a_freq_now: assert property (@(posedge ref_clk) disable iff (rst)
      (ch_wr[g] && req.addr == CH_FREQ && freq_load_q[g] == CNT_ZERO && freq_st_q[g] == HOLD_IDLE)
      |=> freq_live_q[g] == $past(req.data))
      else $error("zero hold-off frequency not applied at once");
    a_freq_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (freq_st_q[g] == HOLD_COUNT && freq_cnt_q[g] > CNT_ONE) |=> $stable(freq_live_q[g]))
      else $error("frequency changed during hold-off");
    a_freq_apply: assert property (@(posedge ref_clk) disable iff (rst)
      freq_done[g] |=> freq_live_q[g] == $past(freq_shadow_q[g]))
      else $error("shadow frequency not applied at count one");
    a_phase_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (sync_evt[g] && ctrl_q[g][CTRL_PHASE_CLR]) |=> phase_q[g] == WORD_ZERO)
      else $error("phase not cleared on sync");
    a_run_gate: assert property (@(posedge ref_clk) disable iff (rst)
      active_q[g] |-> !mode_q[MODE_PROG_LSB + g] && !mode_q[MODE_SLEEP_LSB + g])
      else $error("channel active with program or sleep set");
    a_pin_start: assert property (@(posedge ref_clk) disable iff (rst)
      (pin_rise && ctrl_q[g][CTRL_PIN_EN] && ctrl_q[g][CTRL_START_PIN] && start_st_q[g] == HOLD_IDLE)
      |=> start_st_q[g] == HOLD_COUNT)
      else $error("pin sync did not start the countdown");
  end
  c_start_done: cover property (@(posedge ref_clk) disable iff (rst) start_done[0]);
  c_freq_done: cover property (@(posedge ref_clk) disable iff (rst) freq_done[1]);
  c_phase_clear: cover property (@(posedge ref_clk) disable iff (rst) sync_evt[0] && ctrl_q[0][CTRL_PHASE_CLR]);
  c_mem_write: cover property (@(posedge ref_clk) disable iff (rst) mem_q.we);

endmodule : channel_sync_holdoff_control

// ==== inc/sync_holdoff_pkg.sv ====
// Function
// - Both hold-off counters are 16-bit down-counters.
// - Phase-clear bit zeroes phase on sync.
// - New frequency with a non-zero hold-off waits in shadow until completion.
// - Soft sync or pin sync starts counting.
// - Hard reset puts all channels asleep.
// - Memory writes need program mode set.
// - Channel runs only with program, sleep low.
// - Start plus chip sync write starts countdown.
// - Start delayed by loaded count in cycles.
// - Count of one clears selected sleep bits.
// - Pin sync with enables starts start countdown.
// - Zero frequency hold-off updates oscillator immediately.
// - Hop plus sync counts, loads at one.
// - Frequency load postponed by programmed count.
// - Pin sync with enables starts frequency countdown.
package sync_holdoff_pkg;
  localparam int NUM_CH  = 4;
  localparam int CNT_W   = 16;
  localparam int FREQ_W  = 32;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  // Channel register offsets.
  localparam logic [ADDR_W-1:0] CH_START_HOLDOFF = 8'h00;
  localparam logic [ADDR_W-1:0] CH_OSC_CTRL      = 8'h01;
  localparam logic [ADDR_W-1:0] CH_FREQ          = 8'h02;
  localparam logic [ADDR_W-1:0] CH_FREQ_HOLDOFF  = 8'h03;
  localparam int                CH_MEM_BIT       = 7;
  // Chip-wide register offsets.
  localparam logic [ADDR_W-1:0] EXT_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] EXT_SYNC   = 8'h05;
  localparam logic [ADDR_W-1:0] EXT_STATUS = 8'h06;
  // Oscillator control fields.
  localparam int CTRL_SCALE_LSB = 0;
  localparam int CTRL_PHASE_CLR = 2;
  localparam int CTRL_PDITHER   = 3;
  localparam int CTRL_ADITHER   = 4;
  localparam int CTRL_START_PIN = 5;
  localparam int CTRL_HOP_PIN   = 6;
  localparam int CTRL_PIN_EN    = 7;
  // Mode and sync fields.
  localparam int MODE_PROG_LSB  = 0;
  localparam int MODE_SLEEP_LSB = 4;
  localparam int SYNC_START     = 0;
  localparam int SYNC_HOP       = 1;
  localparam int SYNC_BEAM      = 2;
  localparam int SYNC_SEL_LSB   = 4;
  // Reset values and counter marks.
  localparam logic [7:0]       MODE_RST  = 8'hF0;
  localparam logic [7:0]       CTRL_RST  = 8'h00;
  localparam logic [7:0]       SYNC_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [FREQ_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic {HOLD_IDLE, HOLD_COUNT} hold_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              ext;
    logic [1:0]        ch;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_req_t;

  typedef struct packed {
    logic              we;
    logic [1:0]        ch;
    logic [6:0]        addr;
    logic [DATA_W-1:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic              active;
    logic [1:0]        scale;
    logic              pdither;
    logic              adither;
    logic [FREQ_W-1:0] freq;
    logic [FREQ_W-1:0] phase;
  } chan_out_t;
endpackage : sync_holdoff_pkg

// ==== test/sync_pulse_source.sv ====
`timescale 1ns/1ps
// Far-side pulse source: raises the asynchronous sync pin once per rising edge of fire.
module sync_pulse_source #(
  parameter int HIGH_CYC = 4
) (
  input  wire logic ref_clk,
  input  wire logic fire,
  output logic      sync_pin
);
  // The pin idles low and goes high long enough for the two-flop synchronizer to see it.
  initial begin
    sync_pin = 1'b0;
    forever begin
      @(posedge fire);
      sync_pin = 1'b1;
      repeat (HIGH_CYC) @(posedge ref_clk);
      #1 sync_pin = 1'b0;
    end
  end
endmodule : sync_pulse_source

// ==== test/channel_sync_holdoff_control_tb.sv ====
`timescale 1ns/1ps
module channel_sync_holdoff_control_tb
  import sync_holdoff_pkg::*;
();
  logic                   ref_clk;
  logic                   rst;
  reg_req_t               req;
  logic [DATA_W-1:0]      reg_rdata;
  logic                   reg_rvalid;
  logic                   sync_pin;
  logic                   fire;
  mem_wr_t                mem_wr;
  mem_wr_t                mem_last;
  chan_out_t [NUM_CH-1:0] chan_out;
  int                     num_errors;
  int                     n_compared;
  int                     mem_cnt;
  int                     act_cyc;
  int                     fq_cyc;
  logic [DATA_W-1:0]      q;

  channel_sync_holdoff_control uut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req        (req),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .sync_pin   (sync_pin),
    .mem_wr     (mem_wr),
    .chan_out   (chan_out)
  );

  sync_pulse_source #(.HIGH_CYC(4)) pin_src (
    .ref_clk  (ref_clk),
    .fire     (fire),
    .sync_pin (sync_pin)
  );

  // Free-running 200 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Records every accepted memory write pulse, sampled mid-cycle where it is settled.
  initial mem_cnt = 0;
  always @(negedge ref_clk) begin
    if (mem_wr.we === 1'b1) begin
      mem_cnt++;
      mem_last = mem_wr;
    end
  end

  // Compares one word and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits n edges, then lets their updates settle.
  task automatic stp(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : stp

  // One host access; the answer is taken just after the accepting edge, then an idle edge follows.
  task automatic bus(input logic w, input logic ext, input logic [1:0] ch, input logic [7:0] a,
                     input logic [31:0] d);
    req.wr = w;
    req.rd = !w;
    req.ext = ext;
    req.ch = ch;
    req.addr = a;
    req.data = d;
    @(posedge ref_clk);
    #1 q = reg_rdata;
    if (!w) chk("read valid", 32'h0000_0001, {31'h0, reg_rvalid});
    req = '0;
    @(posedge ref_clk);
    #1;
  endtask : bus

  // Reads a register and compares it.
  task automatic rd_chk(input logic ext, input logic [1:0] ch, input logic [7:0] a,
                        input logic [31:0] exp, input string what);
    bus(1'b0, ext, ch, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask : rd_chk

  function automatic logic [31:0] act(input int c);
    return {31'h0, chan_out[c].active};
  endfunction : act

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end

  // Main sequence of tests.
  initial begin
    req = '0;
    fire = 1'b0;
    rst = 1'b1;
    num_errors = 0;
    n_compared = 0;
    stp(5);
    rst = 1'b0;
    for (int c = 0; c < NUM_CH; c++) chk("reset active", 32'h0000_0000, act(c));
    rd_chk(1'b1, 2'd0, EXT_MODE, 32'h0000_00F0, "mode reset");
    rd_chk(1'b1, 2'd0, EXT_SYNC, 32'h0000_0000, "sync reset");
    bus(1'b1, 1'b1, 2'd0, 8'h07, 32'h0000_00FF);
    rd_chk(1'b1, 2'd0, 8'h07, 32'h0000_0000, "unmapped read");
    $display("test reset finished");

    // Unsynchronized start of channel 0.
    bus(1'b1, 1'b1, 2'd0, EXT_SYNC, 32'h0000_0000);
    bus(1'b1, 1'b0, 2'd0, CH_START_HOLDOFF, 32'h0000_0000);
    bus(1'b1, 1'b1, 2'd0, EXT_MODE, 32'h0000_00E0);
    stp(1);
    chk("ch0 run", 32'h0000_0001, act(0));
    chk("ch1 asleep", 32'h0000_0000, act(1));
    $display("test plain start finished");

    // Immediate frequency load, then phase clear on a sync event; the clear edge is one cycle back.
    bus(1'b1, 1'b0, 2'd0, CH_FREQ_HOLDOFF, 32'h0000_0000);
    bus(1'b1, 1'b0, 2'd0, CH_FREQ, 32'h1234_5678);
    chk("freq now", 32'h1234_5678, chan_out[0].freq);
    rd_chk(1'b0, 2'd0, CH_FREQ, 32'h1234_5678, "freq shadow");
    bus(1'b1, 1'b0, 2'd0, CH_OSC_CTRL, 32'h0000_0004);
    bus(1'b1, 1'b1, 2'd0, EXT_SYNC, 32'h0000_0010);
    chk("phase clear", 32'h1234_5678, chan_out[0].phase);
    stp(1);
    chk("phase resume", 32'h2468_ACF0, chan_out[0].phase);
    rd_chk(1'b0, 2'd0, CH_OSC_CTRL, 32'h0000_0004, "ctrl readback");
    bus(1'b1, 1'b0, 2'd1, CH_OSC_CTRL, 32'h0000_001B);
    chk("ch1 scale dither", 32'h0000_000F,
        {28'h0, chan_out[1].scale, chan_out[1].pdither, chan_out[1].adither});
    $display("test freq and phase finished");

    // Program bit alone keeps a channel idle.
    bus(1'b1, 1'b1, 2'd0, EXT_MODE, 32'h0000_0001);
    stp(1);
    chk("ch0 program idle", 32'h0000_0000, act(0));
    chk("ch1 awake", 32'h0000_0001, act(1));
    rd_chk(1'b1, 2'd0, EXT_STATUS, 32'h0000_000E, "status active");
    bus(1'b1, 1'b1, 2'd0, EXT_MODE, 32'h0000_00F0);
    stp(1);
    chk("ch1 slept", 32'h0000_0000, act(1));
    $display("test mode bits finished");

    // Memory writes only in program mode.
    bus(1'b1, 1'b0, 2'd1, 8'h85, 32'hDEAD_BEEF);
    stp(2);
    chk("mem refused", 32'h0000_0000, mem_cnt);
    bus(1'b1, 1'b1, 2'd0, EXT_MODE, 32'h0000_00F2);
    bus(1'b1, 1'b0, 2'd1, 8'h85, 32'h0BAD_F00D);
    stp(2);
    chk("mem taken", 32'h0000_0001, mem_cnt);
    chk("mem data", 32'h0BAD_F00D, mem_last.data);
    chk("mem place", 32'h0000_0085, {23'h0, mem_last.ch, mem_last.addr});
    bus(1'b1, 1'b1, 2'd0, EXT_MODE, 32'h0000_00F0);
    $display("test memory finished");

    // Soft-sync start of channel 2 with a hold-off of five; the task returns one edge after the trigger.
    bus(1'b1, 1'b0, 2'd2, CH_START_HOLDOFF, 32'h0000_0005);
    bus(1'b1, 1'b1, 2'd0, EXT_SYNC, 32'h0000_0041);
    stp(3);
    chk("start early", 32'h0000_0000, act(2));
    stp(1);
    chk("start on time", 32'h0000_0001, act(2));
    chk("start unselected", 32'h0000_0000, act(3));
    bus(1'b1, 1'b1, 2'd0, EXT_MODE, 32'h0000_00F0);
    stp(10);
    chk("start once", 32'h0000_0000, act(2));
    $display("test soft start finished");

    // Soft-sync hop of channel 1 with a hold-off of three.
    bus(1'b1, 1'b0, 2'd1, CH_FREQ_HOLDOFF, 32'h0000_0003);
    bus(1'b1, 1'b0, 2'd1, CH_FREQ, 32'hAAAA_0001);
    chk("hop shadowed", 32'h0000_0000, chan_out[1].freq);
    bus(1'b1, 1'b1, 2'd0, EXT_SYNC, 32'h0000_0022);
    stp(1);
    chk("hop early", 32'h0000_0000, chan_out[1].freq);
    stp(1);
    chk("hop on time", 32'hAAAA_0001, chan_out[1].freq);
    $display("test soft hop finished");

    // Pin sync starts and hops channel 3 from one pulse: two sync flops and the edge flop, then the hold-off.
    bus(1'b1, 1'b0, 2'd3, CH_START_HOLDOFF, 32'h0000_0002);
    bus(1'b1, 1'b0, 2'd3, CH_FREQ_HOLDOFF, 32'h0000_0004);
    bus(1'b1, 1'b0, 2'd3, CH_FREQ, 32'h0000_0100);
    bus(1'b1, 1'b0, 2'd3, CH_OSC_CTRL, 32'h0000_00E0);
    fire = 1'b1;
    act_cyc = 0;
    fq_cyc = 0;
    for (int i = 1; i <= 20; i++) begin
      stp(1);
      if (act_cyc == 0 && chan_out[3].active === 1'b1) act_cyc = i;
      if (fq_cyc == 0 && chan_out[3].freq === 32'h0000_0100) fq_cyc = i;
    end
    chk("pin start cycle", 32'h0000_0005, 32'(act_cyc));
    chk("pin hop gap", 32'h0000_0002, 32'(fq_cyc - act_cyc));
    $display("test pin sync finished");
    test_done();
  end
endmodule : channel_sync_holdoff_control_tb
